// >>> hdl/adv_decode.sv
// Purpose: combinational decode of the mode strap into an advertisement set
// Assumes: code held stable by the caller
// Notes: reserved codes decode to all zero with the valid bit clear
`timescale 1ns/10ps
module adv_decode
  import strap_cfg_pkg::*;
(
  // mode in
  input wire logic [4:0] mode_code,
  // advertisement out
  output logic [ADV_W-1:0] adv
);
  always_comb begin
    adv = '0;
    adv[ADV_VALID] = 1'b1;
    adv[ADV_PAUSE] = 1'b1;
    adv[ADV_XOVER] = 1'b1;
    unique case (mode_code)
      MODE_GIG_S_ALL, MODE_GIG_M_ALL: begin
        adv[ADV_GIG_FD] = 1'b1;
        adv[ADV_GIG_MULTI] = mode_code[0];
        adv[ADV_GIG_EEE] = 1'b1;
        adv[ADV_FAST_FD] = 1'b1;
        adv[ADV_FAST_HD] = 1'b1;
        adv[ADV_FAST_EEE] = 1'b1;
        adv[ADV_TEN_FD] = 1'b1;
        adv[ADV_TEN_HD] = 1'b1;
        adv[ADV_CAT5] = 1'b1;
      end
      MODE_GIG_S_ONLY, MODE_GIG_M_ONLY: begin
        adv[ADV_GIG_FD] = 1'b1;
        adv[ADV_GIG_MULTI] = mode_code[0];
        adv[ADV_GIG_EEE] = 1'b1;
      end
      MODE_FAST_FH_EEE, MODE_FAST_F_EEE: begin
        adv[ADV_FAST_FD] = 1'b1;
        adv[ADV_FAST_HD] = ~mode_code[0];
        adv[ADV_FAST_EEE] = 1'b1;
      end
      MODE_FAST_TEN_EEE: begin
        adv[ADV_FAST_FD] = 1'b1;
        adv[ADV_FAST_HD] = 1'b1;
        adv[ADV_FAST_EEE] = 1'b1;
        adv[ADV_TEN_FD] = 1'b1;
        adv[ADV_TEN_HD] = 1'b1;
        adv[ADV_CAT5] = 1'b1;
      end
      MODE_FAST_F: adv[ADV_FAST_FD] = 1'b1;
      MODE_FAST_H: adv[ADV_FAST_HD] = 1'b1;
      MODE_FAST_TEN: begin
        adv[ADV_FAST_FD] = 1'b1;
        adv[ADV_FAST_HD] = 1'b1;
        adv[ADV_TEN_FD] = 1'b1;
        adv[ADV_TEN_HD] = 1'b1;
      end
      // other codes are outside this decoder or reserved
      default: adv = '0;
    endcase
    adv[ADV_GIG_HD] = 1'b0;
  end
endmodule

// >>> hdl/strap_cfg_pkg.sv
// Purpose: constants for the strap configuration decoder
// Assumes: five-bit mode strap, four ports, two LEDs per port
// Notes: register offsets are byte addresses on APB
package strap_cfg_pkg;
  localparam int NUM_PORTS = 4;
  localparam int LEDS_PER_PORT = 2;
  localparam int NUM_LEDS = 8;
  localparam logic [4:0] MODE_GIG_S_ALL = 5'h18;
  localparam logic [4:0] MODE_GIG_M_ALL = 5'h19;
  localparam logic [4:0] MODE_GIG_S_ONLY = 5'h1A;
  localparam logic [4:0] MODE_GIG_M_ONLY = 5'h1B;
  localparam logic [4:0] MODE_FAST_FH_EEE = 5'h1C;
  localparam logic [4:0] MODE_FAST_F_EEE = 5'h1D;
  localparam logic [4:0] MODE_FAST_TEN_EEE = 5'h1F;
  localparam logic [4:0] MODE_FAST_F = 5'h15;
  localparam logic [4:0] MODE_FAST_H = 5'h16;
  localparam logic [4:0] MODE_FAST_TEN = 5'h17;
  // advertisement word bit positions
  localparam int ADV_GIG_FD = 0;
  localparam int ADV_GIG_MULTI = 1;
  localparam int ADV_GIG_EEE = 2;
  localparam int ADV_FAST_FD = 3;
  localparam int ADV_FAST_HD = 4;
  localparam int ADV_FAST_EEE = 5;
  localparam int ADV_TEN_FD = 6;
  localparam int ADV_TEN_HD = 7;
  localparam int ADV_PAUSE = 8;
  localparam int ADV_CAT5 = 9;
  localparam int ADV_XOVER = 10;
  localparam int ADV_GIG_HD = 11;
  localparam int ADV_VALID = 12;
  localparam int ADV_W = 13;
  // register byte offsets
  localparam logic [11:0] OFS_ADV = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_LED = 12'h008;
  localparam logic [11:0] OFS_CTRL = 12'h00C;
  localparam logic [11:0] OFS_RAW = 12'h010;
  // field positions in the address, LED and control registers
  localparam int ADDR_PORT_W = 5;
  localparam int ADDR_BCAST_BIT = 20;
  localparam int LED_STYLE_BIT = 8;
  localparam int CTRL_BCAST_BIT = 0;
  localparam int CTRL_POL_LSB = 8;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// >>> hdl/strap_mode_config_decoder.sv
// Purpose: latch board straps at reset release and decode port defaults
// Assumes: strap pins synchronous to CLK and settled during reset
// Notes: straps captured once, on the first edge after reset release
//
// Overview of operation
// - code 11000: full set, gig single-port
// - code 11001: same set, gig multi-port
// - 11010/11011: gig full with EEE only
// - 11100/11101: fast ethernet with EEE, no gig
// - 11111: fast and ten, EEE, cat5, no gig
// - 10101/10110/10111: fast/ten without EEE
// - port addresses are base plus 0..3
// - broadcast strap low enables address zero
// - style strap 0 tri-colour, 1 individual
// - style latched at reset, shared by all LEDs
// - polarity straps set each LED default level
// - dual-use LED pin takes inverted strap polarity
// - gigabit half duplex never advertised
`timescale 1ns/10ps
module strap_mode_config_decoder
  import strap_cfg_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // board straps
  input wire logic [4:0] MODE_STRAP,
  input wire logic [4:0] MGMT_BASE_ADDRESS,
  input wire logic BROADCAST_ADDRESS_STRAP,
  input wire logic LED_STYLE_STRAP,
  input wire logic [NUM_LEDS-1:0] LED_POLARITY_STRAP,
  input wire logic [NUM_LEDS-1:0] LED_DUAL_USE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // decoded defaults
  output logic CONFIG_VALID,
  output logic [ADV_W-1:0] ADVERTISE,
  output logic [4*NUM_PORTS-1:0] PORT_MGMT_ADDRESS_LO,
  output logic [NUM_PORTS-1:0] PORT_MGMT_ADDRESS_HI,
  output logic ADDR_ZERO_ENABLE,
  output logic TRI_COLOUR_LED,
  output logic [NUM_LEDS-1:0] LED_ACTIVE_HIGH
);
  typedef struct packed {
    logic captured;
    logic [4:0] mode;
    logic [4:0] base;
    logic bcast;
    logic style;
    logic [NUM_LEDS-1:0] pol;
    logic [ADV_W-1:0] adv;
    logic [4*NUM_PORTS-1:0] addr_lo;
    logic [NUM_PORTS-1:0] addr_hi;
    logic addr_zero_en;
    logic [NUM_LEDS-1:0] led_pol;
    logic tri_led;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [ADV_W-1:0] adv_dec;

  // port addresses wrap modulo 32 like the five-bit field itself
  function automatic logic [4:0] port_addr(input logic [4:0] base, input int idx);
    port_addr = base + idx[4:0];
  endfunction

  function automatic logic [31:0] addr_word(input state_t s);
    logic [31:0] w;
    w = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      w[p*ADDR_PORT_W +: ADDR_PORT_W] = {s.addr_hi[p], s.addr_lo[p*4 +: 4]};
    end
    w[ADDR_BCAST_BIT] = s.addr_zero_en;
    return w;
  endfunction

  adv_decode u_adv (
    .mode_code(s_q.mode),
    .adv(adv_dec)
  );

  always_comb begin
    logic [4:0] a;
    logic acc;
    logic wr;
    a = '0;
    s_d = s_q;
    // one wait state: data registered in the first access cycle
    acc = PSEL && PENABLE && !s_q.pready;
    // writes land only at the edge where pready is seen high
    wr = PSEL && PENABLE && s_q.pready && PWRITE;
    // capture once after release; later strap motion is ignored
    if (!s_q.captured) begin
      s_d.captured = 1'b1;
      s_d.mode = MODE_STRAP;
      s_d.base = MGMT_BASE_ADDRESS;
      s_d.bcast = BROADCAST_ADDRESS_STRAP;
      s_d.style = LED_STYLE_STRAP;
      s_d.tri_led = ~LED_STYLE_STRAP;
      for (int i = 0; i < NUM_LEDS; i++) begin
        // led doubling as a strap: its pull sets the opposite level
        s_d.pol[i] = LED_DUAL_USE[i] ? ~LED_POLARITY_STRAP[i] : LED_POLARITY_STRAP[i];
      end
    end
    // decoded defaults follow the latched straps one cycle later
    s_d.adv = adv_dec;
    for (int p = 0; p < NUM_PORTS; p++) begin
      a = port_addr(s_q.base, p);
      s_d.addr_lo[p*4 +: 4] = a[3:0];
      s_d.addr_hi[p] = a[4];
    end
    // inverted sense between pin and enable
    if (!s_q.captured) begin
      s_d.addr_zero_en = ~BROADCAST_ADDRESS_STRAP;
      s_d.led_pol = s_d.pol;
    end
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (wr && PADDR == OFS_CTRL) begin
      if (PSTRB[0]) begin
        s_d.addr_zero_en = PWDATA[CTRL_BCAST_BIT];
      end
      if (PSTRB[1]) begin
        s_d.led_pol = PWDATA[CTRL_POL_LSB +: NUM_LEDS];
      end
    end
    if (acc) begin
      s_d.pready = 1'b1;
      s_d.prdata = RD_ZERO;
      unique case (PADDR)
        OFS_ADV: s_d.prdata = {{(32-ADV_W){1'b0}}, s_q.adv};
        OFS_ADDR: s_d.prdata = addr_word(s_q);
        OFS_LED: s_d.prdata = {{(32-LED_STYLE_BIT-1){1'b0}}, s_q.style, s_q.led_pol};
        OFS_CTRL: begin
          s_d.prdata = {{(32-CTRL_POL_LSB-NUM_LEDS){1'b0}}, s_q.led_pol,
                        {(CTRL_POL_LSB-1){1'b0}}, s_q.addr_zero_en};
        end
        OFS_RAW: s_d.prdata = {20'h00000, s_q.bcast, s_q.style, s_q.base, s_q.mode};
        default: s_d.pslverr = 1'b1;
      endcase
      if (PWRITE) begin
        s_d.prdata = RD_ZERO;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign CONFIG_VALID = s_q.adv[ADV_VALID];
  assign ADVERTISE = s_q.adv;
  assign PORT_MGMT_ADDRESS_LO = s_q.addr_lo;
  assign PORT_MGMT_ADDRESS_HI = s_q.addr_hi;
  assign ADDR_ZERO_ENABLE = s_q.addr_zero_en;
  assign TRI_COLOUR_LED = s_q.tri_led;
  assign LED_ACTIVE_HIGH = s_q.led_pol;
endmodule

// >>> verification/strap_board_model.sv
// Purpose: board strap resistors and LED pull networks
// Assumes: fit word is {mode, base, bcast, style, pol, dual}
// Notes: upset flips every pin, used only after capture
`timescale 1ns/10ps
module strap_board_model (
  // fitted levels
  input wire logic [27:0] fit,
  input wire logic upset,
  // strap pins
  output logic [27:0] pin
);
  // board fits decoded mode codes only, never a reserved one
  assign pin = fit ^ {28{upset}};
endmodule

// >>> verification/strap_mode_config_decoder_checker.sv
// Purpose: port checks of strap capture and decode
// Assumes: capture on edge 1, decode on edge 2 after reset
// Notes: bound from the bench top file
`timescale 1ns/10ps
module strap_mode_config_decoder_checker
  import strap_cfg_pkg::*;
(
  // watched ports
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LED_STYLE_STRAP,
  input wire logic BROADCAST_ADDRESS_STRAP,
  input wire logic [NUM_LEDS-1:0] LED_POLARITY_STRAP,
  input wire logic [NUM_LEDS-1:0] LED_DUAL_USE,
  input wire logic [ADV_W-1:0] ADVERTISE,
  input wire logic [4*NUM_PORTS-1:0] PORT_MGMT_ADDRESS_LO,
  input wire logic [NUM_PORTS-1:0] PORT_MGMT_ADDRESS_HI,
  input wire logic ADDR_ZERO_ENABLE,
  input wire logic TRI_COLOUR_LED,
  input wire logic [NUM_LEDS-1:0] LED_ACTIVE_HIGH
);
  logic [1:0] cnt;
  wire logic [4:0] a0 = {PORT_MGMT_ADDRESS_HI[0], PORT_MGMT_ADDRESS_LO[3:0]};
  wire logic [4:0] a3 = {PORT_MGMT_ADDRESS_HI[3], PORT_MGMT_ADDRESS_LO[15:12]};
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) cnt <= 2'h0;
    else if (cnt != 2'h3) cnt <= cnt + 2'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_capt; cnt == 2'h1; endsequence
  sequence s_held; cnt == 2'h3; endsequence
  property p_gig_hd; ADVERTISE[ADV_GIG_HD] == 1'b0; endproperty
  a_gig_hd: assert property (p_gig_hd) else $error("gig half duplex");
  property p_no_gig; !ADVERTISE[ADV_GIG_FD] |-> ADVERTISE[2:1] == 2'b00; endproperty
  a_no_gig: assert property (p_no_gig) else $error("gig extras alone");
  property p_gig_eee; ADVERTISE[ADV_GIG_FD] |-> ADVERTISE[ADV_GIG_EEE]; endproperty
  a_gig_eee: assert property (p_gig_eee) else $error("gig without eee");
  property p_cat; ADVERTISE[ADV_TEN_FD] |-> ADVERTISE[ADV_CAT5] == ADVERTISE[ADV_FAST_EEE];
  endproperty
  a_cat: assert property (p_cat) else $error("cable category");
  property p_addr; s_held |-> a3 == a0 + 5'h3; endproperty
  a_addr: assert property (p_addr) else $error("port address");
  property p_hold; s_held |-> $stable(ADVERTISE) && $stable(TRI_COLOUR_LED); endproperty
  a_hold: assert property (p_hold) else $error("latched value moved");
  property p_bcast; s_capt |-> ADDR_ZERO_ENABLE == !$past(BROADCAST_ADDRESS_STRAP); endproperty
  a_bcast: assert property (p_bcast) else $error("address zero default");
  property p_led; s_capt |-> TRI_COLOUR_LED == !$past(LED_STYLE_STRAP)
    && LED_ACTIVE_HIGH == ($past(LED_POLARITY_STRAP) ^ $past(LED_DUAL_USE)); endproperty
  a_led: assert property (p_led) else $error("led defaults");
endmodule

// >>> verification/strap_mode_config_decoder_tb.sv
// Purpose: self-checking bench for the strap decoder
// Assumes: straps settle in reset, apb answers after one wait state
// Notes: each mode code gets its own reset
`timescale 1ns/10ps
module strap_mode_config_decoder_tb;
  import strap_cfg_pkg::*;
  logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, upset = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [27:0] fit = 28'h0, pin, f;
  logic PREADY, PSLVERR, CONFIG_VALID, ADDR_ZERO_ENABLE, TRI_COLOUR_LED, err;
  logic [12:0] ADVERTISE;
  logic [15:0] PORT_MGMT_ADDRESS_LO;
  logic [3:0] PORT_MGMT_ADDRESS_HI;
  logic [7:0] LED_ACTIVE_HIGH;
  int mismatches = 0, compares = 0, cyc = 0;
  // mode code over expected advertisement
  logic [17:0] tbl [10] = '{18'h317FD, 18'h337FF, 18'h35505, 18'h37507, 18'h39538,
    18'h3B528, 18'h3F7F8, 18'h2B508, 18'h2D510, 18'h2F5D8};
  strap_board_model board (.fit, .upset, .pin);
  strap_mode_config_decoder dut (.CLK, .RESET, .MODE_STRAP(pin[27:23]),
    .MGMT_BASE_ADDRESS(pin[22:18]), .BROADCAST_ADDRESS_STRAP(pin[17]),
    .LED_STYLE_STRAP(pin[16]), .LED_POLARITY_STRAP(pin[15:8]), .LED_DUAL_USE(pin[7:0]),
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB(4'hF), .PRDATA, .PREADY, .PSLVERR,
    .CONFIG_VALID, .ADVERTISE, .PORT_MGMT_ADDRESS_LO, .PORT_MGMT_ADDRESS_HI,
    .ADDR_ZERO_ENABLE, .TRI_COLOUR_LED, .LED_ACTIVE_HIGH);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic boot();
    fit <= f;
    RESET <= 1'b1;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  initial begin
    forever #5 CLK = ~CLK;
  end
  // hang guard, a run needs about 200 cycles
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    for (int i = 0; i < 10; i++) begin
      f = {tbl[i][17:13], 5'(i * 7), i[0], i[1], 8'(i * 37), 8'(8'hA5 >> i)};
      upset <= 1'b0;
      boot();
      // second pass runs with every strap pin flipped
      for (int k = 0; k < 2; k++) begin
        chk(32'(ADVERTISE), 32'(tbl[i][12:0]));
        chk(32'(CONFIG_VALID), 32'h1);
        for (int p = 0; p < 4; p++) begin
          chk(32'({PORT_MGMT_ADDRESS_HI[p], PORT_MGMT_ADDRESS_LO[4*p+:4]}),
            32'(5'(f[22:18] + p)));
        end
        chk(32'({ADDR_ZERO_ENABLE, TRI_COLOUR_LED}), 32'({!f[17], !f[16]}));
        chk(32'(LED_ACTIVE_HIGH), 32'(f[15:8] ^ f[7:0]));
        upset <= 1'b1;
        repeat (3) @(posedge CLK);
      end
      $display("mode test %0d done", i);
    end
    apb(1'b1, OFS_ADV, 32'hFFFF_FFFF);
    apb(1'b0, OFS_ADV, 32'h0);
    chk(rd, 32'(tbl[9][12:0]));
    apb(1'b0, OFS_RAW, 32'h0);
    chk(rd, 32'({f[17], f[16], f[22:18], f[27:23]}));
    apb(1'b1, OFS_CTRL, 32'h0000_5A00);
    // write lands at the ready edge, look one edge later
    @(posedge CLK);
    chk(32'({LED_ACTIVE_HIGH, ADDR_ZERO_ENABLE}), 32'h0B4);
    apb(1'b0, 12'h0F0, 32'h0);
    chk(32'(err), 32'h1);
    $display("register test done");
    finish_test();
  end
endmodule
bind strap_mode_config_decoder strap_mode_config_decoder_checker chk (.CLK, .RESET,
  .LED_STYLE_STRAP, .BROADCAST_ADDRESS_STRAP, .LED_POLARITY_STRAP, .LED_DUAL_USE,
  .ADVERTISE, .PORT_MGMT_ADDRESS_LO, .PORT_MGMT_ADDRESS_HI, .ADDR_ZERO_ENABLE,
  .TRI_COLOUR_LED, .LED_ACTIVE_HIGH);
